// *** hdl/pbi_defines.svh ***
// Constants of the processor bus interface
`ifndef PBI_DEFINES_SVH
`define PBI_DEFINES_SVH
`define PBI_RST_MIN_CYCLES 4
`define PBI_DIV_HALF_FAST 1
`define PBI_DIV_HALF_SLOW 2
`define PBI_DEC_MSB 10
`define PBI_DEC_LSB 3
`define PBI_ACK_DELAY 2
`define PBI_SWAP_ADDR0 12'h000
`define PBI_SWAP_ADDR1 12'h002
`define PBI_SWAP_ADDR2 12'h004
`define PBI_SWAP_ADDR3 12'h006
`endif

// *** hdl/pbi_pkg.sv ***
// Types of the processor bus interface
package pbi_pkg;
    typedef enum logic [1:0] {
        PBI_SYNC_HOSTA,
        PBI_ASYNC_HOSTA,
        PBI_ASYNC_HOSTB,
        PBI_SYNC_HOSTB
    } pbi_mode_e;
    typedef enum {
        PBI_IDLE,
        PBI_WAIT,
        PBI_ACK
    } pbi_state_e;
endpackage

// *** hdl/pbi_clk_div.sv ***
// Divided clock output generator
`timescale 1ns/1ps
`default_nettype none
`include "pbi_defines.svh"
module pbi_clk_div
    import pbi_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic divSelect,
    output logic clkOut
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic clk_r;
    logic clk_nxt;
    logic [1:0] half;

    always_comb begin
        half = divSelect ? 2'(`PBI_DIV_HALF_FAST) : 2'(`PBI_DIV_HALF_SLOW);
        cnt_nxt = cnt_r + 2'h1;
        clk_nxt = clk_r;
        if (cnt_r + 2'h1 >= half) begin
            cnt_nxt = 2'h0;
            clk_nxt = ~clk_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= 2'h0;
            clk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clkOut = clk_r;
endmodule
`default_nettype wire

// *** hdl/pbi_host_port.sv ***
// Processor bus interface with RAM port arbiter
`timescale 1ns/1ps
`default_nettype none
`include "pbi_defines.svh"
module pbi_host_port
    import pbi_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hostFamilySelect,
    input wire logic timingSelect,
    input wire logic ram4kMode,
    input wire logic divideSelect,
    output logic dividedClockOut,
    input wire logic writeStrobeOrPhaseClock,
    input wire logic readStrobeOrDirection,
    input wire logic externalChipSelectN,
    input wire logic addressLatchStrobe,
    input wire logic [10:0] addressInputs,
    input wire logic [DATA_W-1:0] dataBusIn,
    output logic [DATA_W-1:0] dataBusOut,
    output logic dataBusOe,
    output logic readyAckOut,
    output logic hostRamReq,
    output logic hostRamWrite,
    output logic [ADDR_W-1:0] hostRamAddr,
    output logic [DATA_W-1:0] hostRamWdata,
    input wire logic [DATA_W-1:0] ramRdata,
    input wire logic seqReq,
    input wire logic seqWrite,
    input wire logic [ADDR_W-1:0] seqAddr,
    input wire logic [DATA_W-1:0] seqWdata,
    output logic seqGrant,
    output logic [DATA_W-1:0] seqRdata,
    output logic ramEn,
    output logic ramWe,
    output logic [ADDR_W-1:0] ramAddr,
    output logic [DATA_W-1:0] ramWdata
);
    if (ADDR_W != 12 || DATA_W != 8) begin : g_param_check
        $error("pbi_host_port supports a 12-bit address and 8-bit data only");
    end

    pbi_mode_e mode;
    logic isFamB;
    logic isSync;
    logic [7:0] lowLatch_r;
    logic [7:0] lowLatch_nxt;
    logic [ADDR_W-1:0] addr;
    logic addr11;
    logic selected;
    logic rdActive;
    logic wrActive;
    logic access;
    logic accPrev_r;
    logic accStart;
    logic swapHit;
    logic [ADDR_W-1:0] effAddr;
    pbi_state_e state_r;
    pbi_state_e state_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] rdData_nxt;
    logic pendRd_r;
    logic pendRd_nxt;
    logic oe_r;
    logic oe_nxt;
    logic rdy_r;
    logic rdy_nxt;

    pbi_clk_div u_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .divSelect(divideSelect),
        .clkOut(dividedClockOut)
    );

    assign mode = pbi_mode_e'({hostFamilySelect, hostFamilySelect ^ ~timingSelect});
    assign isFamB = hostFamilySelect;
    assign isSync = timingSelect;

    always_comb begin
        lowLatch_nxt = lowLatch_r;
        if (mode == PBI_SYNC_HOSTA && addressLatchStrobe) begin
            lowLatch_nxt = dataBusIn;
        end
    end

    always_comb begin
        addr11 = 1'b0;
        case (mode)
            PBI_SYNC_HOSTA: addr11 = ram4kMode & externalChipSelectN;
            PBI_ASYNC_HOSTA: addr11 = ram4kMode & addressLatchStrobe;
            PBI_SYNC_HOSTB: addr11 = ram4kMode & addressLatchStrobe;
            PBI_ASYNC_HOSTB: addr11 = ram4kMode & writeStrobeOrPhaseClock;
            default: addr11 = 1'b0;
        endcase
        if (mode == PBI_SYNC_HOSTA) begin
            addr = {addr11, addressInputs[10:8], lowLatch_r};
            selected = (addr[`PBI_DEC_MSB:`PBI_DEC_LSB] == 8'h00);
        end else begin
            addr = {addr11, addressInputs};
            selected = ~externalChipSelectN;
        end
        if (isFamB) begin
            rdActive = selected & readStrobeOrDirection;
            wrActive = selected & ~readStrobeOrDirection;
            if (isSync) begin
                rdActive = rdActive & writeStrobeOrPhaseClock;
                wrActive = wrActive & writeStrobeOrPhaseClock;
            end
        end else begin
            rdActive = selected & ~readStrobeOrDirection;
            wrActive = selected & ~writeStrobeOrPhaseClock;
        end
    end

    assign access = rdActive | wrActive;
    assign accStart = access & ~accPrev_r;
    assign swapHit = isFamB && (addr[ADDR_W-1:1] == 11'(`PBI_SWAP_ADDR0 >> 1) ||
        addr[ADDR_W-1:1] == 11'(`PBI_SWAP_ADDR1 >> 1) ||
        addr[ADDR_W-1:1] == 11'(`PBI_SWAP_ADDR2 >> 1) ||
        addr[ADDR_W-1:1] == 11'(`PBI_SWAP_ADDR3 >> 1));
    assign effAddr = swapHit ? {addr[ADDR_W-1:1], ~addr[0]} : addr;

    // Host request and arbitration
    assign hostRamReq = accStart;
    assign hostRamWrite = wrActive;
    assign hostRamAddr = effAddr;
    assign hostRamWdata = dataBusIn;
    assign seqGrant = seqReq & ~accStart;
    assign ramEn = accStart | seqReq;
    assign ramWe = accStart ? wrActive : seqWrite;
    assign ramAddr = accStart ? effAddr : seqAddr;
    assign ramWdata = accStart ? dataBusIn : seqWdata;
    assign seqRdata = ramRdata;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rdData_nxt = rdData_r;
        pendRd_nxt = 1'b0;
        rdy_nxt = rdy_r;
        if (pendRd_r) begin
            rdData_nxt = ramRdata;
        end
        case (state_r)
            PBI_IDLE: begin
                rdy_nxt = 1'b0;
                if (accStart) begin
                    pendRd_nxt = rdActive;
                    cnt_nxt = 2'h0;
                    state_nxt = PBI_WAIT;
                end
            end
            PBI_WAIT: begin
                cnt_nxt = cnt_r + 2'h1;
                if (!access) begin
                    state_nxt = PBI_IDLE;
                end else if (cnt_r == 2'(`PBI_ACK_DELAY - 1)) begin
                    rdy_nxt = ~isSync;
                    state_nxt = PBI_ACK;
                end
            end
            PBI_ACK: begin
                if (!access) begin
                    rdy_nxt = 1'b0;
                    state_nxt = PBI_IDLE;
                end
            end
            default: state_nxt = PBI_IDLE;
        endcase
        oe_nxt = rdActive;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lowLatch_r <= 8'h00;
            accPrev_r <= 1'b0;
            state_r <= PBI_IDLE;
            cnt_r <= 2'h0;
            rdData_r <= 8'h00;
            pendRd_r <= 1'b0;
            oe_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            lowLatch_r <= lowLatch_nxt;
            accPrev_r <= access;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rdData_r <= rdData_nxt;
            pendRd_r <= pendRd_nxt;
            oe_r <= oe_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign dataBusOut = rdData_r;
    assign dataBusOe = oe_r & rdActive;
    assign readyAckOut = rdy_r;

    chk_bus_idle_reset: assert property (@(posedge mclk)
        $past(sys_rst) |-> !dataBusOe)
        else $error("Data bus driven after reset");
    chk_oe_needs_read: assert property (@(posedge mclk) disable iff (sys_rst)
        dataBusOe |-> rdActive && $past(rdActive))
        else $error("Data bus driven outside a read");
    chk_host_priority: assert property (@(posedge mclk) disable iff (sys_rst)
        hostRamReq && seqReq |-> !seqGrant && ramAddr == hostRamAddr)
        else $error("Sequencer granted over host");
    chk_seq_served: assert property (@(posedge mclk) disable iff (sys_rst)
        seqReq && !hostRamReq |-> seqGrant && ramEn && ramAddr == seqAddr)
        else $error("Sequencer not served");
    chk_sync_no_ack: assert property (@(posedge mclk) disable iff (sys_rst)
        isSync && $stable(isSync) |=> !readyAckOut)
        else $error("Ready in synchronous mode");
    chk_async_ack: assert property (@(posedge mclk) disable iff (sys_rst)
        accStart && !isSync ##1 (access && !isSync)[*3] |-> readyAckOut)
        else $error("Ready missing in asynchronous mode");
    chk_int_decode: assert property (@(posedge mclk) disable iff (sys_rst)
        mode == PBI_SYNC_HOSTA && addr[10:3] != 8'h00 |-> !access)
        else $error("Internal select outside window");
    chk_ext_select: assert property (@(posedge mclk) disable iff (sys_rst)
        mode != PBI_SYNC_HOSTA && externalChipSelectN |-> !access)
        else $error("Access without external select");
    chk_swap_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        isFamB && addr == `PBI_SWAP_ADDR0 |-> effAddr == 12'h001)
        else $error("Byte swap missing");
endmodule
`default_nettype wire

// *** verification/pbi_host_model.sv ***
// Host processor model driving the bus pins
`timescale 1ns/1ps
`default_nettype none
module pbi_host_model
    import pbi_pkg::*;
(
    input wire logic mclk,
    input wire logic hostFamilySelect,
    input wire logic timingSelect,
    input wire logic dataBusOe,
    input wire logic readyAckOut,
    input wire logic [7:0] dataBusOut,
    output logic writeStrobeOrPhaseClock,
    output logic readStrobeOrDirection,
    output logic externalChipSelectN,
    output logic addressLatchStrobe,
    output logic [10:0] addressInputs,
    output logic [7:0] dataBusIn
);
    logic [7:0] drv = 8'h5a;
    logic hostOe = 1'b0;
    // Undriven bus changes every cycle
    always @(posedge mclk) if (!hostOe && !dataBusOe) drv <= ~drv;
    assign dataBusIn = dataBusOe ? dataBusOut : drv;
    task automatic idle(input logic fam);
        writeStrobeOrPhaseClock = !fam;
        readStrobeOrDirection = 1'b1;
        externalChipSelectN = 1'b1;
        addressLatchStrobe = 1'b0;
        addressInputs = 11'h000;
        hostOe = 1'b0;
    endtask
    task automatic acc(input logic rd, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] q);
        int n;
        n = 0;
        addressInputs = a[10:0];
        if (timingSelect && !hostFamilySelect) begin
            drv = a[7:0];
            hostOe = 1'b1;
            addressLatchStrobe = 1'b1;
            externalChipSelectN = a[11];
            @(posedge mclk);
            #1 addressLatchStrobe = 1'b0;
        end else begin
            externalChipSelectN = 1'b0;
            addressLatchStrobe = a[11] && (timingSelect || !hostFamilySelect);
        end
        drv = wd;
        hostOe = !rd;
        if (hostFamilySelect) begin
            readStrobeOrDirection = rd;
            writeStrobeOrPhaseClock = timingSelect ? 1'b1 : a[11];
        end else if (rd) readStrobeOrDirection = 1'b0;
        else writeStrobeOrPhaseClock = 1'b0;
        // Async waits for ready, sync runs a fixed length
        do begin
            @(posedge mclk);
            #1 n++;
        end while (timingSelect ? n < 4 : readyAckOut !== 1'b1 && n < 20);
        // Byte host: only the low data lane is used
        q = dataBusOut;
        @(posedge mclk);
        #1 idle(hostFamilySelect);
        @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// *** verification/test_pbi_host_port.sv ***
// Self-checking bench of the processor bus interface
`timescale 1ns/1ps
`default_nettype none
module test_pbi_host_port
    import pbi_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic hostFamilySelect, timingSelect, ram4kMode, divideSelect, dividedClockOut;
    logic writeStrobeOrPhaseClock, readStrobeOrDirection, externalChipSelectN;
    logic addressLatchStrobe, dataBusOe, readyAckOut, hostRamReq, hostRamWrite;
    logic seqReq, seqWrite, seqGrant, ramEn, ramWe, lastWe, lastGrant, sawReady;
    logic lastHostWr;
    logic [7:0] lastWdata;
    logic [10:0] addressInputs;
    logic [7:0] dataBusIn, dataBusOut, hostRamWdata, seqWdata, seqRdata, ramWdata;
    logic [7:0] ramRdata = 8'h00;
    logic [11:0] hostRamAddr, seqAddr, ramAddr, lastAddr;
    logic [7:0] mem [0:4095];
    int errorCnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int reqCnt = 0;
    pbi_host_port dut (
        .mclk(mclk), .sys_rst(sys_rst), .hostFamilySelect(hostFamilySelect),
        .timingSelect(timingSelect), .ram4kMode(ram4kMode), .divideSelect(divideSelect),
        .dividedClockOut(dividedClockOut), .writeStrobeOrPhaseClock(writeStrobeOrPhaseClock),
        .readStrobeOrDirection(readStrobeOrDirection), .externalChipSelectN(externalChipSelectN),
        .addressLatchStrobe(addressLatchStrobe), .addressInputs(addressInputs),
        .dataBusIn(dataBusIn), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
        .readyAckOut(readyAckOut), .hostRamReq(hostRamReq), .hostRamWrite(hostRamWrite),
        .hostRamAddr(hostRamAddr), .hostRamWdata(hostRamWdata), .ramRdata(ramRdata),
        .seqReq(seqReq), .seqWrite(seqWrite), .seqAddr(seqAddr), .seqWdata(seqWdata),
        .seqGrant(seqGrant), .seqRdata(seqRdata), .ramEn(ramEn), .ramWe(ramWe),
        .ramAddr(ramAddr), .ramWdata(ramWdata)
    );
    pbi_host_model host (
        .mclk(mclk), .hostFamilySelect(hostFamilySelect), .timingSelect(timingSelect),
        .dataBusOe(dataBusOe), .readyAckOut(readyAckOut), .dataBusOut(dataBusOut),
        .writeStrobeOrPhaseClock(writeStrobeOrPhaseClock),
        .readStrobeOrDirection(readStrobeOrDirection),
        .externalChipSelectN(externalChipSelectN), .addressLatchStrobe(addressLatchStrobe),
        .addressInputs(addressInputs), .dataBusIn(dataBusIn)
    );
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (ramEn && ramWe) mem[ramAddr] <= ramWdata;
        if (ramEn) ramRdata <= mem[ramAddr];
    end
    task automatic printVerdict();
        if (errorCnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (readyAckOut === 1'b1) sawReady <= 1'b1;
        if (hostRamReq === 1'b1) begin
            reqCnt <= reqCnt + 1;
            {lastAddr, lastWe, lastGrant} <= {ramAddr, ramWe, seqGrant};
            {lastHostWr, lastWdata} <= {hostRamWrite, hostRamWdata};
        end
        if (cycles == 5000) begin
            errorCnt++;
            printVerdict();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic setMode(input logic fam, input logic syn);
        sys_rst = 1'b1;
        {hostFamilySelect, timingSelect} = {fam, syn};
        divideSelect = !(fam && syn);
        host.idle(fam);
        sawReady = 1'b0;
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
                        input logic [11:0] ea);
        logic [7:0] q;
        host.acc(rd, a, d, q);
        check(lastAddr, ea);
        check(lastWe, !rd);
        check(lastHostWr, !rd);
        if (!rd) check(lastWdata, d);
        check(dataBusOe, 1'b0);
        if (rd) check(q, d);
    endtask
    task automatic tDivider();
        logic prev;
        int t;
        for (int s = 0; s < 2; s++) begin
            divideSelect = s[0];
            t = 0;
            repeat (8) @(posedge mclk);
            #1 prev = dividedClockOut;
            repeat (16) begin
                @(posedge mclk);
                #1 t += (dividedClockOut !== prev);
                prev = dividedClockOut;
            end
            check(12'(t), s ? 12'h010 : 12'h008);
        end
    endtask
    task automatic tModes();
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            setMode(m[1], m[1] ~^ m[0]);
            d = 8'h3c + 8'(m);
            xfer(1'b0, 12'h805, d, 12'h805);
            xfer(1'b1, 12'h805, d, 12'h805);
            xfer(1'b0, 12'h002, ~d, {11'h001, m[1]});
            xfer(1'b1, 12'h002, ~d, {11'h001, m[1]});
            check(sawReady, !timingSelect);
        end
    endtask
    task automatic tDecode();
        int n;
        logic [7:0] q;
        setMode(1'b0, 1'b1);
        n = reqCnt;
        host.acc(1'b1, 12'h00c, 8'h00, q);
        check(12'(reqCnt - n), 12'h000);
    endtask
    task automatic tArb();
        setMode(1'b0, 1'b0);
        {seqReq, seqWrite, seqAddr, seqWdata} = {1'b1, 1'b1, 12'h123, 8'h5c};
        @(posedge mclk);
        #1 check(seqGrant, 1'b1);
        check(ramAddr, 12'h123);
        seqWrite = 1'b0;
        xfer(1'b0, 12'h040, 8'h96, 12'h040);
        check(lastGrant, 1'b0);
        xfer(1'b1, 12'h040, 8'h96, 12'h040);
        xfer(1'b1, 12'h123, 8'h5c, 12'h123);
        seqAddr = 12'h040;
        @(posedge mclk);
        #1 check(seqRdata, 8'h96);
        seqReq = 1'b0;
    endtask
    initial begin
        {hostFamilySelect, timingSelect, ram4kMode, divideSelect} = 4'h7;
        {seqReq, seqWrite, seqAddr, seqWdata} = 22'h000000;
        host.idle(1'b0);
        repeat (16) @(posedge mclk);
        #1 check(dataBusOe, 1'b0);
        check(readyAckOut, 1'b0);
        check(dividedClockOut, 1'b0);
        sys_rst = 1'b0;
        tDivider();
        tModes();
        tDecode();
        tArb();
        printVerdict();
    end
endmodule
`default_nettype wire
